/* File: design/seam_calc_pkg.sv */
// constants, register map and types for the seam split calculator
// assumes a single 40 MHz clock domain and an axi4-lite master on the register side
package seam_calc_pkg;

   // bus geometry
   localparam int ADDR_W = 8;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // clock rate, for reference by the bench
   localparam int CLK_PERIOD_NS = 25;

   // filter and pipe constants
   localparam int FRAC = 14;
   localparam int FILTER_TAP_COUNT = 7;
   localparam int PIXELS_PER_CLOCK = 2;
   localparam int SEXC_HALF = FILTER_TAP_COUNT / 2;
   localparam logic [15:0] SRC_EXCESS =
      16'((SEXC_HALF + PIXELS_PER_CLOCK - 1) / PIXELS_PER_CLOCK * PIXELS_PER_CLOCK);
   localparam logic [15:0] PPC_MASK = 16'(PIXELS_PER_CLOCK - 1);
   localparam logic [5:0] DIV_STEPS = 6'h20;

   // control, status and configuration registers
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam logic [7:0] SRC_DST_OFS = 8'h08;
   localparam logic [7:0] BORDER_OFS = 8'h0C;
   localparam logic [7:0] PLANE_OFS = 8'h10;
   localparam logic [7:0] MEM_SIZE_OFS = 8'h14;
   localparam logic [7:0] CURSOR_OFS = 8'h18;
   localparam logic [7:0] PLANE_DEXC_OFS = 8'h1C;

   // result registers, read only
   localparam logic [7:0] EXCESS_OFS = 8'h20;
   localparam logic [7:0] SCALE_OFS = 8'h24;
   localparam logic [7:0] PRIGHT_OFS = 8'h28;
   localparam logic [7:0] LPHASE_OFS = 8'h2C;
   localparam logic [7:0] RPHASE_OFS = 8'h30;
   localparam logic [7:0] PIPE_OFS = 8'h34;
   localparam logic [7:0] WINPOS_OFS = 8'h38;
   localparam logic [7:0] HACTIVE_OFS = 8'h3C;
   localparam logic [7:0] LOFF_OFS = 8'h40;
   localparam logic [7:0] LSIZE_OFS = 8'h44;
   localparam logic [7:0] ROFF_OFS = 8'h48;
   localparam logic [7:0] RSIZE_OFS = 8'h4C;
   localparam logic [7:0] CURPOS_OFS = 8'h50;
   localparam logic [7:0] PLANE_POS_OFS = 8'h54;

   // control field positions
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_PSCALE_BIT = 1;
   localparam int CTRL_LNEG_BIT = 2;
   localparam int CTRL_ROT_LSB = 4;

   // status field positions
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_DONE_BIT = 1;
   localparam int ST_UP_BIT = 2;
   localparam int ST_STRADDLE_BIT = 3;
   localparam int ST_LCUR_EN_BIT = 4;
   localparam int ST_RCUR_EN_BIT = 5;
   localparam int ST_LCUR_NEG_BIT = 6;
   localparam int ST_RCUR_NEG_BIT = 7;

   // phase word: trip flag on top, 14.14 phase below
   localparam int PHASE_TRIP_BIT = 31;

   // calculation sequence
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_DIV_T,
      ST_DIV_E,
      ST_DIV_A,
      ST_FINISH
   } calc_state_t;

endpackage

/* File: design/dual_pipe_seam_split_calc.sv */
// seam split calculator: axi4-lite slave that derives dual pipe scaler settings
// assumes software writes the settings, pulses start and reads back the results
module dual_pipe_seam_split_calc
   import seam_calc_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // write address channel
   input wire logic awvalid,
   output logic awready,
   input wire logic [seam_calc_pkg::ADDR_W-1:0] awaddr,
   input wire logic [2:0] awprot,
   // write data channel
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   // write response channel
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // read address channel
   input wire logic arvalid,
   output logic arready,
   input wire logic [seam_calc_pkg::ADDR_W-1:0] araddr,
   input wire logic [2:0] arprot,
   // read data channel
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp
);
   import seam_calc_pkg::*;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic [15:0] s;
      logic [15:0] d;
      logic [15:0] lb;
      logic [15:0] rb;
      logic [15:0] pp;
      logic [15:0] full_horizontal_plane_size;
      logic [15:0] hsz;
      logic [15:0] vsz;
      logic [15:0] global_cursor_position;
      logic [15:0] cs;
      logic [15:0] pdexc;
      logic pscale;
      logic lneg;
      logic [1:0] rot;
      calc_state_t st;
      logic [5:0] cnt;
      logic [31:0] num;
      logic [31:0] den;
      logic [31:0] quo;
      logic [32:0] rem;
      logic [15:0] sf_t;
      logic [15:0] sf_a;
      logic [15:0] dexc;
      logic [31:0] pright;
      logic [31:0] lphase;
      logic [31:0] rphase;
      logic busy;
      logic done;
   } state_t;

   state_t q;
   state_t n;

   // byte lane merge for partial writes
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] m;
      m = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            m[8*i+:8] = nw[8*i+:8];
         end
      end
      return m;
   endfunction

   // excess choice and plane split, all from current settings
   logic up;
   logic [15:0] se;
   logic [15:0] pse;
   logic straddle;
   logic [15:0] left_part;
   logic [15:0] right_part;
   logic [15:0] lmain;
   logic [15:0] rmain;
   logic [15:0] loff_main;
   logic [15:0] roff_main;
   logic [31:0] loff_w;
   logic [31:0] roff_w;
   logic [31:0] lsize_w;
   logic [31:0] rsize_w;

   assign up = q.d > q.s;
   assign pse = up ? SRC_EXCESS : 16'h0;
   assign se = !up ? 16'h0 : (q.pscale ? q.pdexc : SRC_EXCESS);
   // hps holds the post-rotation size
   assign straddle = ({1'b0, q.pp} + {1'b0, q.full_horizontal_plane_size}) > {1'b0, q.s};
   assign left_part = straddle ? q.s - q.pp : q.full_horizontal_plane_size;
   assign right_part = straddle ? q.full_horizontal_plane_size - (q.s - q.pp) : 16'h0;
   assign lmain = left_part + pse;
   assign rmain = right_part + pse;
   assign loff_main = q.rot[1] ? right_part - pse : 16'h0;
   assign roff_main = q.rot[1] ? 16'h0 : left_part - pse;
   // odd rotation codes split heights, even codes split widths
   assign loff_w = q.rot[0] ? {loff_main, 16'h0} : {16'h0, loff_main};
   assign roff_w = q.rot[0] ? {roff_main, 16'h0} : {16'h0, roff_main};
   assign lsize_w = q.rot[0] ? {lmain, q.hsz} : {q.vsz, lmain};
   assign rsize_w = q.rot[0] ? {rmain, q.hsz} : {q.vsz, rmain};

   // cursor placement around the seam window
   logic signed [17:0] g;
   logic signed [17:0] win_lo;
   logic signed [17:0] seam_lo;
   logic signed [17:0] win_hi;
   logic lcur_en;
   logic rcur_en;
   logic lcur_neg;
   logic rcur_neg;
   logic [15:0] rcur_mag;

   assign g = signed'({2'h0, q.global_cursor_position});
   assign seam_lo = signed'({2'h0, q.s}) - signed'({2'h0, se});
   assign win_lo = seam_lo - signed'({2'h0, q.cs});
   assign win_hi = signed'({2'h0, q.s}) + signed'({2'h0, se});
   assign lcur_en = g < win_hi;
   assign rcur_en = g >= win_lo;
   assign lcur_neg = (g < win_lo) ? q.lneg : 1'b0;
   assign rcur_neg = g < seam_lo;
   assign rcur_mag = (g < seam_lo) ? 16'(seam_lo - g) : 16'(g - win_hi);

   // one copy of the state is filled here and registered below
   always_comb begin
      logic [31:0] wd;
      logic [32:0] r;
      logic [15:0] raw;
      logic [31:0] first;
      logic [31:0] diff;
      n = q;
      wd = '0;
      r = '0;
      raw = '0;
      first = '0;
      diff = '0;
      n.awready = 1'b0;
      n.wready = 1'b0;
      n.arready = 1'b0;

      // write: take address and data together, answer one cycle later
      if (!q.awready && !q.bvalid && awvalid && wvalid) begin
         n.awready = 1'b1;
         n.wready = 1'b1;
      end
      if (q.awready) begin
         n.bvalid = 1'b1;
         n.bresp = RESP_OKAY;
         case (awaddr)
            CTRL_OFS: begin
               wd = merge({26'h0, q.rot, 1'b0, q.lneg, q.pscale, 1'b0}, wdata, wstrb);
               n.pscale = wd[CTRL_PSCALE_BIT];
               n.lneg = wd[CTRL_LNEG_BIT];
               n.rot = wd[CTRL_ROT_LSB+:2];
               // start while busy is ignored
               if (wd[CTRL_START_BIT] && wstrb[0] && !q.busy) begin
                  n.busy = 1'b1;
                  n.done = 1'b0;
                  n.st = ST_DIV_T;
                  n.cnt = DIV_STEPS;
                  n.num = {2'h0, q.s, 14'h0} + {17'h0, q.d[15:1]};
                  n.den = {16'h0, q.d};
                  n.quo = '0;
                  n.rem = '0;
               end
            end
            SRC_DST_OFS: {n.d, n.s} = merge({q.d, q.s}, wdata, wstrb);
            BORDER_OFS: {n.rb, n.lb} = merge({q.rb, q.lb}, wdata, wstrb);
            PLANE_OFS: {n.full_horizontal_plane_size, n.pp} = merge({q.full_horizontal_plane_size, q.pp}, wdata, wstrb);
            MEM_SIZE_OFS: {n.vsz, n.hsz} = merge({q.vsz, q.hsz}, wdata, wstrb);
            CURSOR_OFS: {n.cs, n.global_cursor_position} = merge({q.cs, q.global_cursor_position}, wdata, wstrb);
            PLANE_DEXC_OFS: n.pdexc = 16'(merge({16'h0, q.pdexc}, wdata, wstrb));
            STATUS_OFS, EXCESS_OFS, SCALE_OFS, PRIGHT_OFS, LPHASE_OFS, RPHASE_OFS,
            PIPE_OFS, WINPOS_OFS, HACTIVE_OFS, LOFF_OFS, LSIZE_OFS, ROFF_OFS,
            RSIZE_OFS, CURPOS_OFS, PLANE_POS_OFS: begin
               n.bresp = RESP_OKAY; // read-only, write dropped
            end
            default: begin
               n.bresp = RESP_SLVERR;
            end
         endcase
      end
      if (q.bvalid && bready) begin
         n.bvalid = 1'b0;
      end

      // read: take address, answer one cycle later
      if (!q.arready && !q.rvalid && arvalid) begin
         n.arready = 1'b1;
      end
      if (q.arready) begin
         n.rvalid = 1'b1;
         n.rresp = RESP_OKAY;
         case (araddr)
            CTRL_OFS: n.rdata = {26'h0, q.rot, 1'b0, q.lneg, q.pscale, 1'b0};
            STATUS_OFS: n.rdata = {24'h0, rcur_neg, lcur_neg, rcur_en, lcur_en,
                                   straddle, up, q.done, q.busy};
            SRC_DST_OFS: n.rdata = {q.d, q.s};
            BORDER_OFS: n.rdata = {q.rb, q.lb};
            PLANE_OFS: n.rdata = {q.full_horizontal_plane_size, q.pp};
            MEM_SIZE_OFS: n.rdata = {q.vsz, q.hsz};
            CURSOR_OFS: n.rdata = {q.cs, q.global_cursor_position};
            PLANE_DEXC_OFS: n.rdata = {16'h0, q.pdexc};
            EXCESS_OFS: n.rdata = {q.dexc, se};
            SCALE_OFS: n.rdata = {q.sf_a, q.sf_t};
            PRIGHT_OFS: n.rdata = q.pright;
            LPHASE_OFS: n.rdata = q.lphase;
            RPHASE_OFS: n.rdata = q.rphase;
            PIPE_OFS: n.rdata = {q.d + q.dexc, q.s + se};
            WINPOS_OFS: n.rdata = {16'h0, q.lb};
            HACTIVE_OFS: n.rdata = {q.d + q.rb, q.d + q.lb};
            LOFF_OFS: n.rdata = loff_w;
            LSIZE_OFS: n.rdata = lsize_w;
            ROFF_OFS: n.rdata = roff_w;
            RSIZE_OFS: n.rdata = rsize_w;
            CURPOS_OFS: n.rdata = {rcur_mag, q.global_cursor_position};
            PLANE_POS_OFS: n.rdata = {16'h0, q.pp};
            default: begin
               n.rdata = 32'h0;
               n.rresp = RESP_SLVERR;
            end
         endcase
      end
      if (q.rvalid && rready) begin
         n.rvalid = 1'b0;
      end

      // shared restoring divider, one quotient bit per cycle
      if (q.st != ST_IDLE && q.st != ST_FINISH && q.cnt != 6'h0) begin
         r = {q.rem[31:0], q.num[31]};
         n.num = {q.num[30:0], 1'b0};
         if (r >= {1'b0, q.den}) begin
            r = r - {1'b0, q.den};
            n.quo = {q.quo[30:0], 1'b1};
         end else begin
            n.quo = {q.quo[30:0], 1'b0};
         end
         n.rem = r;
         n.cnt = q.cnt - 6'h1;
      end

      // calculation sequence
      case (q.st)
         ST_IDLE: begin
         end
         ST_DIV_T: begin
            if (q.cnt == 6'h0) begin
               n.sf_t = q.quo[15:0]; // rounded 2.14
               n.st = ST_DIV_E;
               n.cnt = DIV_STEPS;
               n.num = {2'h0, q.s + se, 14'h0} + {17'h0, q.quo[15:1]};
               n.den = {16'h0, q.quo[15:0]};
               n.quo = '0;
               n.rem = '0;
            end
         end
         ST_DIV_E: begin
            if (q.cnt == 6'h0) begin
               raw = q.quo[15:0] - q.d + PPC_MASK;
               raw = raw & ~PPC_MASK;
               n.dexc = up ? raw : 16'h0;
               n.st = ST_DIV_A;
               n.cnt = DIV_STEPS;
               n.num = {2'h0, q.s + se, 14'h0} + {17'h0, n.dexc[15:1] + q.d[15:1]};
               n.den = {16'h0, q.d + n.dexc};
               n.quo = '0;
               n.rem = '0;
            end
         end
         ST_DIV_A: begin
            if (q.cnt == 6'h0) begin
               n.sf_a = q.quo[15:0];
               n.pright = q.quo[15:0] * (q.d - q.dexc);
               n.st = ST_FINISH;
            end
         end
         ST_FINISH: begin
            first = {2'h0, q.s - se, 14'h0};
            // only a positive phase may be given, so pick the lagging side
            if (first >= q.pright) begin
               diff = first - q.pright;
               n.lphase = {1'b1, 3'h0, diff[27:0]};
               n.rphase = 32'h0;
            end else begin
               diff = q.pright - first;
               n.lphase = 32'h0;
               n.rphase = {1'b1, 3'h0, diff[27:0]};
            end
            n.busy = 1'b0;
            n.done = 1'b1;
            n.st = ST_IDLE;
         end
         default: begin
            n.st = ST_IDLE;
            n.busy = 1'b0;
         end
      endcase
   end

   // state register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   // bus outputs come straight from the state register
   assign awready = q.awready;
   assign wready = q.wready;
   assign bvalid = q.bvalid;
   assign bresp = q.bresp;
   assign arready = q.arready;
   assign rvalid = q.rvalid;
   assign rdata = q.rdata;
   assign rresp = q.rresp;

endmodule

/* File: tb/seam_calc_monitor.sv */
// checker of bus timing and result words of the seam calculator
// assumes it is bound to the calculator and sees its ports only
module seam_calc_monitor
   import seam_calc_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // write side
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [1:0] bresp,
   // read side
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [seam_calc_pkg::ADDR_W-1:0] araddr,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic [31:0] rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   logic [ADDR_W-1:0] ra_q;
   // address of the read under way
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ra_q <= 8'hFF;
      end else if (arvalid && arready) begin
         ra_q <= araddr;
      end
   end
   // handshakes and held answers
   property p_aw_pair; awready |-> wready && $past(awvalid && wvalid); endproperty
   a_aw_pair: assert property (p_aw_pair) else $error("write taken without both valids");
   property p_b_next; awready |=> bvalid && !awready; endproperty
   a_b_next: assert property (p_b_next) else $error("write response late");
   property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");
   property p_r_next; arready |=> rvalid && !arready; endproperty
   a_r_next: assert property (p_r_next) else $error("read data late");
   property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data dropped");
   // result words
   property p_dexc_even; rvalid && ra_q == EXCESS_OFS |-> !rdata[16]; endproperty
   a_dexc_even: assert property (p_dexc_even) else $error("odd excess");
   property p_no_exc;
      rvalid && ra_q == EXCESS_OFS && rdata[15:0] == 16'h0000 |-> rdata[31:16] == 16'h0000;
   endproperty
   a_no_exc: assert property (p_no_exc) else $error("excess without source excess");
   property p_ltrip; rvalid && ra_q == LPHASE_OFS && rdata[27:0] != 28'h0 |-> rdata[31]; endproperty
   a_ltrip: assert property (p_ltrip) else $error("left trip bit clear");
   property p_rtrip; rvalid && ra_q == RPHASE_OFS && rdata[27:0] != 28'h0 |-> rdata[31]; endproperty
   a_rtrip: assert property (p_rtrip) else $error("right trip bit clear");
   property p_winpos; rvalid && ra_q == WINPOS_OFS |-> rdata[31:16] == 16'h0000; endproperty
   a_winpos: assert property (p_winpos) else $error("right window offset");
   property p_rpos; rvalid && ra_q == PLANE_POS_OFS |-> rdata[31:16] == 16'h0000; endproperty
   a_rpos: assert property (p_rpos) else $error("right plane offset");
   // main scenarios
   c_slverr: cover property (bvalid && bresp == RESP_SLVERR);
   c_lphase: cover property (rvalid && ra_q == LPHASE_OFS && rdata[31]);
   c_rphase: cover property (rvalid && ra_q == RPHASE_OFS && rdata[31]);
endmodule

bind dual_pipe_seam_split_calc seam_calc_monitor seam_calc_monitor_i (.aclk, .aresetn,
   .awvalid, .awready, .wvalid, .wready, .bvalid, .bready, .bresp, .arvalid, .arready,
   .araddr, .rvalid, .rready, .rdata);

/* File: tb/axi_host_model.sv */
// axi4-lite master standing in for software on the register bus
// assumes one clock; its tasks are entered just after a rising edge
module axi_host_model
   import seam_calc_pkg::*;
(
   // clock
   input wire logic aclk,
   // write channels
   output logic awvalid,
   input wire logic awready,
   output logic [seam_calc_pkg::ADDR_W-1:0] awaddr,
   output logic [2:0] awprot,
   output logic wvalid,
   input wire logic wready,
   output logic [31:0] wdata,
   output logic [3:0] wstrb,
   input wire logic bvalid,
   output logic bready,
   input wire logic [1:0] bresp,
   // read channels
   output logic arvalid,
   input wire logic arready,
   output logic [seam_calc_pkg::ADDR_W-1:0] araddr,
   output logic [2:0] arprot,
   input wire logic rvalid,
   output logic rready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp
);
   timeunit 1ns;
   timeprecision 1ps;
   int lag = 0; // cycles before taking an answer
   logic [3:0] strb_sel = 4'hF; // byte lanes offered with the next write
   // quiet bus at time zero
   initial begin
      {awvalid, wvalid, bready, arvalid, rready, awprot, arprot} = 11'h000;
      {awaddr, araddr, wdata} = 48'h0;
      wstrb = 4'hF;
   end
   // one write: both channels offered, each dropped when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic [1:0] got;
      got = 2'b00;
      awaddr <= a;
      wdata <= d;
      wstrb <= strb_sel;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (got != 2'b11) begin
         @(posedge aclk);
         if (awready) begin
            got[0] = 1'b1;
            awvalid <= 1'b0;
         end
         if (wready) begin
            got[1] = 1'b1;
            wvalid <= 1'b0;
         end
      end
      repeat (lag) @(posedge aclk);
      bready <= 1'b1;
      do @(posedge aclk); while (!bvalid);
      r = bresp;
      bready <= 1'b0;
   endtask
   // one read: address held until taken, data taken with rvalid
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      repeat (lag) @(posedge aclk);
      rready <= 1'b1;
      do @(posedge aclk); while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
endmodule

/* File: tb/tb.sv */
// self-checking bench of the seam split calculator over its register bus
// assumes the bus master model and the bound checker beside the design
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import seam_calc_pkg::*;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [2:0] awprot, arprot;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   int error_cnt = 0;
   int n_checks = 0;
   int cyc = 0;
   // design and the master that drives it
   dual_pipe_seam_split_calc dual_pipe_seam_split_calc_i (.aclk, .aresetn, .awvalid, .awready,
      .awaddr, .awprot, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid,
      .arready, .araddr, .arprot, .rvalid, .rready, .rdata, .rresp);
   axi_host_model axi_host_model_i (.aclk, .awvalid, .awready, .awaddr, .awprot, .wvalid,
      .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot,
      .rvalid, .rready, .rdata, .rresp);
   // clock
   initial begin
      aclk = 1'b0;
      forever #(CLK_PERIOD_NS / 2.0) aclk = ~aclk;
   end
   // cuts a hung run short
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         $display("[FAIL] run length expected 20000 seen more");
         conclude();
      end
   end
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", what, e, g);
      end
   endtask
   // register write and read with comparison
   task automatic wc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = RESP_OKAY);
      logic [1:0] r;
      axi_host_model_i.wr(a, d, r);
      chk($sformatf("bresp %h", a), 32'(e), 32'(r));
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e,
      input logic [31:0] m = 32'hFFFF_FFFF, input logic [1:0] er = RESP_OKAY);
      logic [31:0] v;
      logic [1:0] r;
      axi_host_model_i.rd(a, v, r);
      chk($sformatf("rresp %h", a), 32'(er), 32'(r));
      chk($sformatf("reg %h", a), e & m, v & m);
   endtask
   function automatic int rdiv(input int a, input int b);
      return (a + b / 2) / b;
   endfunction
   function automatic logic [31:0] ph(input int x);
      return (x != 0) ? {4'h8, 28'(x)} : 32'h0;
   endfunction
   // one start, expected results worked out from the sizes
   task automatic run_case(input int s, input int d, input logic ps);
      int se, de, sft, sfa, lph, rph, n;
      longint pr, fp;
      logic [31:0] v;
      logic [1:0] r;
      se = (d > s) ? (ps ? 8 : (((7 - 1) / 2) + 1) / 2 * 2) : 0;
      sft = rdiv(s * 16384, d);
      de = (d > s) ? rdiv((s + se) * 16384, sft) - d : 0;
      de = (de + 1) / 2 * 2;
      sfa = rdiv((s + se) * 16384, d + de);
      pr = longint'(sfa) * (d - de);
      fp = longint'(s - se) * 16384;
      lph = (fp >= pr) ? int'(fp - pr) : 0;
      rph = (fp < pr) ? int'(pr - fp) : 0;
      wc(PLANE_DEXC_OFS, 32'h0000_0008);
      wc(SRC_DST_OFS, {16'(d), 16'(s)});
      wc(CTRL_OFS, {30'h0, ps, 1'b1});
      v = 32'h0;
      for (n = 0; n < 60 && v[ST_DONE_BIT] !== 1'b1; n++) begin
         axi_host_model_i.rd(STATUS_OFS, v, r);
      end
      rc(STATUS_OFS, {29'h0, 1'(d > s), 2'b10}, 32'h0000_0007);
      wc(EXCESS_OFS, 32'hFFFF_FFFF);
      rc(EXCESS_OFS, {16'(de), 16'(se)});
      rc(SCALE_OFS, {16'(sfa), 16'(sft)});
      rc(PRIGHT_OFS, 32'(pr));
      rc(LPHASE_OFS, ph(lph), (lph | rph) ? 32'hFFFF_FFFF : 32'h0FFF_FFFF);
      rc(RPHASE_OFS, ph(rph));
      rc(PIPE_OFS, {16'(d + de), 16'(s + se)});
      wc(BORDER_OFS, {16'd20, 16'd10});
      rc(WINPOS_OFS, 32'h0000_000A);
      rc(HACTIVE_OFS, {16'(d + 20), 16'(d + 10)});
      $display("case s %0d d %0d ended", s, d);
   endtask
   // straddling plane split at one rotation, seam at 960, excess 4
   task automatic plane_case(input logic [1:0] rot);
      logic [15:0] left_part, right_part;
      logic [31:0] lo, ls, ro, rs;
      left_part = 16'd960 - 16'd900;
      right_part = 16'd200 - left_part;
      ls = rot[0] ? {left_part + 16'd4, 16'd300} : {16'd180, left_part + 16'd4};
      rs = rot[0] ? {right_part + 16'd4, 16'd300} : {16'd180, right_part + 16'd4};
      ro = (rot == 2'd0) ? {16'h0, left_part - 16'd4} : (rot == 2'd1) ? {left_part - 16'd4, 16'h0} : 32'h0;
      lo = (rot == 2'd2) ? {16'h0, right_part - 16'd4} : (rot == 2'd3) ? {right_part - 16'd4, 16'h0} : 32'h0;
      wc(CTRL_OFS, {26'h0, rot, 4'h0});
      wc(PLANE_OFS, {16'd200, 16'd900});
      wc(MEM_SIZE_OFS, {16'd180, 16'd300});
      rc(LOFF_OFS, lo);
      rc(LSIZE_OFS, ls);
      rc(ROFF_OFS, ro);
      rc(RSIZE_OFS, rs);
      rc(PLANE_POS_OFS, 32'h0, 32'hFFFF_0000);
      rc(STATUS_OFS, 32'h0000_0008, 32'h0000_0008);
      $display("plane rotation %0d ended", rot);
   endtask
   // cursor enables and signs in status bits 7..4, positions
   task automatic cur_case(input int g, input logic [3:0] st, input logic [3:0] sm,
      input logic [31:0] pos, input logic [31:0] pm);
      wc(CURSOR_OFS, {16'd64, 16'(g)});
      rc(STATUS_OFS, {24'h0, st, 4'h0}, {24'h0, sm, 4'h0});
      rc(CURPOS_OFS, pos, pm);
      $display("cursor at %0d ended", g);
   endtask
   // main sequence
   initial begin
      aresetn = 1'b0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rc(STATUS_OFS, 32'h0000_0020);
      rc(SRC_DST_OFS, 32'h0);
      rc(8'hFC, 32'h0, 32'hFFFF_FFFF, RESP_SLVERR);
      wc(8'hF8, 32'h1234_5678, RESP_SLVERR);
      axi_host_model_i.strb_sel = 4'h3;
      wc(BORDER_OFS, 32'hAAAA_5555);
      axi_host_model_i.strb_sel = 4'hF;
      rc(BORDER_OFS, 32'h0000_5555);
      $display("bus checks ended");
      run_case(500, 400, 1'b0);
      axi_host_model_i.lag = 2;
      run_case(100, 250, 1'b0);
      axi_host_model_i.lag = 0;
      run_case(960, 2576, 1'b1);
      run_case(960, 2576, 1'b0);
      for (int k = 0; k < 4; k++) begin
         plane_case(2'(k));
      end
      wc(PLANE_OFS, {16'd40, 16'd900});
      rc(STATUS_OFS, 32'h0, 32'h0000_0008);
      wc(CTRL_OFS, 32'h0000_0004);
      cur_case(891, 4'b0101, 4'b0111, {16'h0, 16'd891}, 32'h0000_FFFF);
      cur_case(892, 4'b1011, 4'b1111, {16'd64, 16'd892}, 32'hFFFF_FFFF);
      cur_case(956, 4'b0011, 4'b1011, {16'd956 - 16'd964, 16'h0}, 32'hFFFF_0000);
      cur_case(964, 4'b0010, 4'b1111, {16'd0, 16'h0}, 32'hFFFF_0000);
      cur_case(965, 4'b0010, 4'b1011, {16'd1, 16'h0}, 32'hFFFF_0000);
      conclude();
   end
endmodule
